// *** hw/dfrb_read.sv ***
// Read-transaction path of a DDR octal-bus flash: command capture,
// latency count, strobe-aligned data, wrapped/linear/hybrid addressing.
// Assumes bus clock far slower than clk_i; array data arrives same cycle.
//
// Function
// - Word zero gives read and burst type
// - Array access starts after half-page address
// - Third word gives start word position
// - After latency, toggle strobe with new data
// - Keep delivering while clock toggles, select low
// - Wrapped burst steps modulo burst length
// - Linear burst crosses page boundaries
// - Linear burst rolls over at array end
// - Hybrid: one wrapped burst then linear
// - Wrapped reads from array, ID tables, secure region; this path reads the array only
// - Select high at clock low stops driving
// - Short wrapped bursts insert no wait
// - Long wrapped burst may wait at crossing
// - Codes 0..11 give 5..16 clocks
// - Latency code from config bits 7:4
// - Nonvolatile config defaults to 16 clocks
// - Linear wait equals latency minus words delivered
// - Top bit one means read
// - Burst bit zero wrapped, one linear
// - Upper byte rising, lower byte falling
// - Low three bits pick start word
`timescale 1ns/1ps
`include "dfrb_map.svh"
module dfrb_read
    import dfrb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cs_b_i,
    input wire logic bus_clk_i,
    input wire logic clock_complement_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic dq_oe_o,
    output logic read_data_strobe_o,
    output logic read_data_strobe_oe_o,
    input wire logic [7:0] active_config_reg_i,
    input wire logic active_is_volatile_i,
    input wire logic [7:0] volatile_config_reg_i,
    input wire logic nv_load_i,
    input wire logic [7:0] nv_load_value_i,
    output logic [7:0] nonvolatile_config_reg_o,
    input wire logic hybrid_en_i,
    input wire logic [1:0] wrap_len_i,
    output logic [`DFRB_ADDR_W-1:0] mem_addr_o,
    output logic mem_rd_o,
    input wire logic [15:0] mem_data_i,
    output logic busy_o
);
    typedef struct packed {
        dfrb_state_e state;
        logic clk_d;
        logic [1:0] ca_cnt;
        logic half;
        logic [47:0] ca;
        logic burst_linear;
        logic hybrid_wrap;
        logic [4:0] lat_cnt;
        logic [4:0] lat_clks;
        logic [4:0] words;
        logic [4:0] gap_cnt;
        logic first_cross;
        logic [`DFRB_ADDR_W-1:0] addr;
        logic [`DFRB_ADDR_W-1:0] wrap_base;
        logic [15:0] word;
        logic [7:0] dq;
        logic dq_oe;
        logic strobe;
        logic strobe_oe;
        logic mem_rd;
        logic [7:0] nonvolatile_config_reg;
    } dfrb_st_s;

    dfrb_st_s st_r;
    dfrb_st_s st_nxt;
    dfrb_bus_in_s pins;
    dfrb_bus_in_s sp;

    assign pins = '{cs_b: cs_b_i, clk: bus_clk_i,
                    clock_complement: clock_complement_i, dq: dq_i};

    dfrb_sync u_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .pins_i(pins),
        .sync_o(sp)
    );

    function automatic logic [4:0] lat_decode(input logic [3:0] code);
        // Reserved codes fall back to the longest latency, the safe side
        if (code > `DFRB_LAT_MAX_CODE) begin
            lat_decode = `DFRB_LAT_LO_CLKS + 5'(`DFRB_LAT_MAX_CODE);
        end else begin
            lat_decode = `DFRB_LAT_LO_CLKS + 5'(code);
        end
    endfunction : lat_decode

    function automatic logic [`DFRB_ADDR_W-1:0] wrap_mask(
        input logic [1:0] len);
        case (len)
            `DFRB_WRAP_16B: wrap_mask = `DFRB_WRAP_MASK16;
            `DFRB_WRAP_32B: wrap_mask = `DFRB_WRAP_MASK32;
            default: wrap_mask = `DFRB_WRAP_MASK64;
        endcase
    endfunction : wrap_mask

    // Half-page from the first two words, word position from the last byte
    function automatic logic [`DFRB_ADDR_W-1:0] start_addr(
        input logic [47:0] ca_in,
        input logic [7:0] last_byte);
        start_addr = {ca_in[`DFRB_CA_ROW_HI-8:`DFRB_CA_ROW_LO-8],
                      last_byte[`DFRB_CA_COL_HI:`DFRB_CA_COL_LO]};
    endfunction : start_addr

    // Linear step; the top word rolls over so the whole array streams
    function automatic logic [`DFRB_ADDR_W-1:0] lin_step(
        input logic [`DFRB_ADDR_W-1:0] a);
        if (a == `DFRB_ADDR_LAST) begin
            lin_step = `DFRB_ADDR_ZERO;
        end else begin
            lin_step = a + `DFRB_ONE_WORD;
        end
    endfunction : lin_step

    // Wait owed at the first crossing: latency less the words already sent
    // Done_words excludes the word now leaving, hence the extra one
    function automatic logic [4:0] cross_wait(
        input logic [4:0] lat,
        input logic [4:0] done_words);
        if (lat > done_words + `DFRB_ONE5) begin
            cross_wait = lat - done_words - `DFRB_ONE5;
        end else begin
            cross_wait = `DFRB_ZERO5;
        end
    endfunction : cross_wait

    // One full wrap has gone out once every slot of the block was sent,
    // counted from the start word, not from the block base
    function automatic logic hybrid_done(
        input logic [4:0] sent,
        input logic [`DFRB_ADDR_W-1:0] mask);
        hybrid_done = sent == mask[4:0];
    endfunction : hybrid_done

    logic edge_any;
    logic rise;
    logic [3:0] lat_code;
    logic [7:0] cfg_sel;
    logic [`DFRB_ADDR_W-1:0] msk;
    logic [`DFRB_ADDR_W-1:0] lin_next;
    logic [`DFRB_ADDR_W-1:0] wrap_next;
    logic page_end;
    logic [4:0] wait_clks;

    always_comb begin
        edge_any = sp.clk != st_r.clk_d;
        rise = sp.clk && !st_r.clk_d;
        cfg_sel = active_is_volatile_i ? volatile_config_reg_i
                                       : st_r.nonvolatile_config_reg;
        lat_code = cfg_sel[`DFRB_LAT_HI:`DFRB_LAT_LO];
        msk = wrap_mask(wrap_len_i);
        lin_next = lin_step(st_r.addr);
        wrap_next = st_r.wrap_base
                  | ((st_r.addr + `DFRB_ONE_WORD) & msk);
        page_end = (st_r.addr & `DFRB_PAGE_MASK) == `DFRB_PAGE_MASK;
        wait_clks = cross_wait(st_r.lat_clks, st_r.words);
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.clk_d = sp.clk;
        st_nxt.mem_rd = 1'b0;
        if (nv_load_i) begin
            st_nxt.nonvolatile_config_reg = nv_load_value_i;
        end
        case (st_r.state)
            DFRB_IDLE: begin
                st_nxt.dq_oe = 1'b0;
                st_nxt.strobe_oe = 1'b0;
                st_nxt.strobe = 1'b0;
                st_nxt.ca_cnt = 2'h0;
                st_nxt.half = 1'b0;
                // Start only from clock low with select asserted
                if (!sp.cs_b && !sp.clk && sp.clock_complement) begin
                    st_nxt.state = DFRB_CMD;
                end
            end
            DFRB_CMD: begin
                if (edge_any) begin
                    st_nxt.ca = {st_r.ca[39:0], sp.dq};
                    st_nxt.half = !st_r.half;
                    if (st_r.half) begin
                        st_nxt.ca_cnt = st_r.ca_cnt + 2'h1;
                        if (st_r.ca_cnt == `DFRB_CA_WORDS - 2'h1) begin
                            st_nxt.lat_clks = lat_decode(lat_code);
                            st_nxt.lat_cnt = `DFRB_ONE5;
                            st_nxt.words = `DFRB_ZERO5;
                            st_nxt.first_cross = 1'b1;
                            // Reserved address bits are ignored, not checked
                            st_nxt.addr = start_addr(st_r.ca, sp.dq);
                            st_nxt.wrap_base =
                                start_addr(st_r.ca, sp.dq) & ~msk;
                            st_nxt.burst_linear =
                                st_r.ca[`DFRB_CA_BURST_BIT-8];
                            st_nxt.hybrid_wrap = hybrid_en_i;
                            // Reads only; writes are handled elsewhere
                            if (st_r.ca[`DFRB_CA_RW_BIT-8]) begin
                                st_nxt.state = DFRB_LAT;
                            end else begin
                                st_nxt.state = DFRB_DONE;
                            end
                        end else if (st_r.ca_cnt == 2'h1) begin
                            st_nxt.mem_rd = 1'b1;
                        end
                    end
                end
            end
            DFRB_LAT: begin
                st_nxt.strobe_oe = 1'b1;
                if (rise) begin
                    if (st_r.lat_cnt >= st_r.lat_clks) begin
                        st_nxt.state = DFRB_DATA;
                        st_nxt.word = mem_data_i;
                        st_nxt.dq = mem_data_i[15:8];
                        st_nxt.dq_oe = 1'b1;
                        st_nxt.strobe = 1'b1;
                    end else begin
                        st_nxt.lat_cnt = st_r.lat_cnt + `DFRB_ONE5;
                    end
                end
            end
            DFRB_DATA: begin
                if (edge_any && !sp.clk) begin
                    st_nxt.dq = st_r.word[7:0];
                    st_nxt.strobe = 1'b0;
                    st_nxt.words = st_r.words + `DFRB_ONE5;
                    st_nxt.mem_rd = 1'b1;
                    if (st_r.burst_linear || !st_r.hybrid_wrap) begin
                        if (st_r.burst_linear) begin
                            st_nxt.addr = lin_next;
                        end else begin
                            st_nxt.addr = wrap_next;
                        end
                    end else if (hybrid_done(st_r.words, msk)) begin
                        // Wrapped block done once; go on linearly
                        st_nxt.burst_linear = 1'b1;
                        st_nxt.hybrid_wrap = 1'b0;
                        st_nxt.addr = lin_step(st_r.wrap_base | msk);
                    end else begin
                        st_nxt.addr = wrap_next;
                    end
                    // Only linear and 64-byte wraps can cross a page
                    if (page_end && st_r.first_cross
                        && (st_r.burst_linear
                            || wrap_len_i == `DFRB_WRAP_64B)) begin
                        st_nxt.first_cross = 1'b0;
                        if (wait_clks != `DFRB_ZERO5) begin
                            st_nxt.gap_cnt = wait_clks;
                            st_nxt.state = DFRB_GAP;
                        end
                    end
                end else if (rise) begin
                    st_nxt.word = mem_data_i;
                    st_nxt.dq = mem_data_i[15:8];
                    st_nxt.strobe = 1'b1;
                end
            end
            DFRB_GAP: begin
                // Strobe frozen low so the host captures nothing
                st_nxt.strobe = 1'b0;
                // Every owed clock passes in full; data resumes on the
                // rise after the last one
                if (rise) begin
                    if (st_r.gap_cnt == `DFRB_ZERO5) begin
                        st_nxt.state = DFRB_DATA;
                        st_nxt.word = mem_data_i;
                        st_nxt.dq = mem_data_i[15:8];
                        st_nxt.strobe = 1'b1;
                    end else begin
                        st_nxt.gap_cnt = st_r.gap_cnt - `DFRB_ONE5;
                    end
                end
            end
            DFRB_DONE: begin
                st_nxt.dq_oe = 1'b0;
                st_nxt.strobe_oe = 1'b0;
            end
            default: begin
                st_nxt.state = DFRB_IDLE;
            end
        endcase
        // Select release ends any transaction and frees the bus
        // The clock level is not checked here: a host that breaks the
        // low-clock rule still gets a released bus, the safe outcome
        if (sp.cs_b && st_r.state != DFRB_IDLE) begin
            st_nxt.state = DFRB_IDLE;
            st_nxt.dq_oe = 1'b0;
            st_nxt.strobe_oe = 1'b0;
            st_nxt.strobe = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
            st_r.state <= DFRB_IDLE;
            st_r.nonvolatile_config_reg <= `DFRB_NONVOLATILE_CONFIG_REG_DEFAULT;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dq_o = st_r.dq;
    assign dq_oe_o = st_r.dq_oe;
    assign read_data_strobe_o = st_r.strobe;
    assign read_data_strobe_oe_o = st_r.strobe_oe;
    assign nonvolatile_config_reg_o = st_r.nonvolatile_config_reg;
    assign mem_addr_o = st_r.addr;
    assign mem_rd_o = st_r.mem_rd;
    assign busy_o = st_r.state != DFRB_IDLE;
endmodule : dfrb_read

// *** hw/dfrb_map.svh ***
// Constants of the octal-bus flash read path: bit positions, codes, counts.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DFRB_MAP_SVH
`define DFRB_MAP_SVH
`define DFRB_CA_RW_BIT 47
`define DFRB_CA_BURST_BIT 45
`define DFRB_CA_ROW_HI 37
`define DFRB_CA_ROW_LO 16
`define DFRB_CA_COL_HI 2
`define DFRB_CA_COL_LO 0
`define DFRB_ADDR_W 25
`define DFRB_LAT_LO_CLKS 5'h05
`define DFRB_LAT_MAX_CODE 4'hB
`define DFRB_LAT_HI 7
`define DFRB_LAT_LO 4
`define DFRB_NONVOLATILE_CONFIG_REG_DEFAULT 8'hB0
`define DFRB_PAGE_MASK 25'h000000F
`define DFRB_PAGE_WORDS 5'h10
`define DFRB_WRAP_16B 2'h0
`define DFRB_WRAP_32B 2'h1
`define DFRB_WRAP_64B 2'h2
`define DFRB_WRAP_MASK16 25'h0000007
`define DFRB_WRAP_MASK32 25'h000000F
`define DFRB_WRAP_MASK64 25'h000001F
`define DFRB_ADDR_LAST 25'h1FFFFFF
`define DFRB_ADDR_ZERO 25'h0000000
`define DFRB_ONE_WORD 25'h0000001
`define DFRB_ZERO5 5'h00
`define DFRB_ONE5 5'h01
`define DFRB_CA_WORDS 2'h3
`endif

// *** hw/dfrb_pkg.sv ***
// Types shared by the flash read path: states and bus carriers.
// Assumes dfrb_map.svh is on the include path.
`include "dfrb_map.svh"
package dfrb_pkg;
    typedef enum logic [2:0] {
        DFRB_IDLE,
        DFRB_CMD,
        DFRB_LAT,
        DFRB_DATA,
        DFRB_GAP,
        DFRB_DONE
    } dfrb_state_e;

    typedef struct packed {
        logic cs_b;
        logic clk;
        logic clock_complement;
        logic [7:0] dq;
    } dfrb_bus_in_s;

    typedef struct packed {
        logic [7:0] dq;
        logic dq_oe;
        logic read_data_strobe;
        logic strobe_oe;
    } dfrb_bus_out_s;

    typedef struct packed {
        logic [`DFRB_ADDR_W-1:0] addr;
        logic rd;
    } dfrb_mem_req_s;
endpackage : dfrb_pkg

// *** hw/dfrb_sync.sv ***
// Two-flop synchroniser bank for the pin inputs of the flash read path.
// Assumes pins are asynchronous to clk_i.
`timescale 1ns/1ps
module dfrb_sync
    import dfrb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire dfrb_bus_in_s pins_i,
    output dfrb_bus_in_s sync_o
);
    typedef struct packed {
        dfrb_bus_in_s meta;
        dfrb_bus_in_s sync;
    } dfrb_sync_s;

    dfrb_sync_s st_r;
    dfrb_sync_s st_nxt;

    always_comb begin
        st_nxt.meta = pins_i;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '{meta: '{cs_b: 1'b1, clk: 1'b0,
                              clock_complement: 1'b1, dq: 8'h00},
                      sync: '{cs_b: 1'b1, clk: 1'b0,
                              clock_complement: 1'b1, dq: 8'h00}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_o = st_r.sync;
endmodule : dfrb_sync

// *** verif/dfrb_read_checker.sv ***
// Port checker for the flash read path.
// Assumes it is bound to dfrb_read and sees only its ports.
`timescale 1ns/1ps
module dfrb_read_checker (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cs_b_i,
    input wire logic bus_clk_i,
    input wire logic dq_oe_o,
    input wire logic read_data_strobe_o,
    input wire logic read_data_strobe_oe_o,
    input wire logic nv_load_i,
    input wire logic [7:0] nv_load_value_i,
    input wire logic [7:0] nonvolatile_config_reg_o,
    input wire logic mem_rd_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_nv_default: assert property ($rose(rst_b_i) && !nv_load_i
        |-> nonvolatile_config_reg_o == 8'hB0) else $error("nv default");
    a_nv_load: assert property (nv_load_i |=>
        nonvolatile_config_reg_o == $past(nv_load_value_i))
        else $error("nv load lost");
    a_cs_release: assert property (cs_b_i [*5]
        |-> !dq_oe_o && !read_data_strobe_oe_o) else $error("drive after cs");
    a_idle_quiet: assert property (!busy_o |-> !dq_oe_o)
        else $error("drive while idle");
    a_strobe_rise: assert property ($rose(read_data_strobe_o)
        |-> $past(bus_clk_i, 2)) else $error("strobe rise off clock");
    a_strobe_fall: assert property ($fell(read_data_strobe_o)
        |-> !$past(bus_clk_i, 2)) else $error("strobe fall off clock");
    a_strobe_still: assert property ($stable(bus_clk_i) [*6]
        |=> $stable(read_data_strobe_o)) else $error("strobe moved");
    a_rd_pulse: assert property (mem_rd_o |=> !mem_rd_o)
        else $error("array read not a pulse");
    a_oe_pair: assert property (dq_oe_o
        |-> read_data_strobe_oe_o && busy_o) else $error("data without strobe");
    c_data: cover property ($rose(dq_oe_o));
    c_done: cover property ($fell(busy_o));
    c_load: cover property (nv_load_i);
endmodule : dfrb_read_checker

bind dfrb_read dfrb_read_checker dfrb_read_checker_inst (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .cs_b_i(cs_b_i),
    .bus_clk_i(bus_clk_i),
    .dq_oe_o(dq_oe_o),
    .read_data_strobe_o(read_data_strobe_o),
    .read_data_strobe_oe_o(read_data_strobe_oe_o),
    .nv_load_i(nv_load_i),
    .nv_load_value_i(nv_load_value_i),
    .nonvolatile_config_reg_o(nonvolatile_config_reg_o),
    .mem_rd_o(mem_rd_o),
    .busy_o(busy_o)
);

// *** verif/dfrb_host_model.sv ***
// Host controller model: select, clock pair, command bytes, capture.
// Assumes clk_i of 25 ns; a bus half period is four clk_i cycles.
`timescale 1ns/1ps
module dfrb_host_model (
    input wire logic clk_i,
    output logic cs_b_o,
    output logic bus_clk_o,
    output logic cc_o,
    output logic [7:0] dq_o,
    input wire logic [7:0] rd_dq_i,
    input wire logic strobe_i
);
    logic [7:0] got[$];
    int at[$];
    int tog = 0;
    logic s_q = 1'h0;
    initial begin
        cs_b_o = 1'h1;
        bus_clk_o = 1'h0; // Idle clock low, complement high
        cc_o = 1'h1;
        dq_o = 8'h00;
    end
    // Only strobe edges count, so wait clocks yield no byte
    always @(posedge clk_i) begin
        if (strobe_i !== s_q) begin
            got.push_back(rd_dq_i);
            at.push_back(tog);
        end
        s_q <= strobe_i;
    end
    task automatic run(input logic [47:0] ca, input int halves);
        got.delete();
        at.delete();
        tog = 0;
        @(negedge clk_i);
        cs_b_o = 1'h0;
        for (int i = 0; i < 6; i++) begin
            dq_o = ca[47 - 8 * i -: 8]; // Top byte first
            repeat (2) @(negedge clk_i);
            bus_clk_o = ~bus_clk_o;
            cc_o = ~cc_o;
            repeat (2) @(negedge clk_i);
        end
        dq_o = ~dq_o; // Released lines must not look like the last byte
        for (int i = 0; i < halves; i++) begin
            bus_clk_o = ~bus_clk_o; // Clocks through latency and data
            cc_o = ~cc_o;
            tog = i + 1;
            repeat (4) @(negedge clk_i);
        end
        cs_b_o = 1'h1; // Even count leaves clock low
        repeat (8) @(negedge clk_i);
    endtask : run
endmodule : dfrb_host_model

// *** verif/tb_top.sv ***
// Testbench for the flash read path: host model, array stand-in, scenarios.
// Assumes dfrb_read, its checker and the host model are compiled first.
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'h0;
    logic rst_b_i = 1'h0;
    logic act_vol = 1'h1;
    logic nv_load = 1'h0;
    logic hyb = 1'h0;
    logic [1:0] wlen = 2'h0;
    logic [7:0] vcfg = 8'hB0;
    logic [7:0] nv_val = 8'h00;
    logic cs_b, bclk, cclk, dq_oe, rds, rds_oe, mem_rd, busy;
    logic [7:0] hdq, rdq, nonvolatile_config_reg;
    logic [24:0] maddr;
    logic [15:0] mdata;
    int n_fail = 0;
    int compares = 0;
    always #12.5 clk_i = ~clk_i;
    // Word content follows its address so order errors show up
    assign mdata = {~maddr[7:0], maddr[7:0]};
    dfrb_host_model dfrb_host_model_inst (.clk_i(clk_i), .cs_b_o(cs_b),
        .bus_clk_o(bclk), .cc_o(cclk), .dq_o(hdq), .rd_dq_i(rdq),
        .strobe_i(rds));
    dfrb_read dfrb_read_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .cs_b_i(cs_b), .bus_clk_i(bclk), .clock_complement_i(cclk),
        .dq_i(hdq), .dq_o(rdq), .dq_oe_o(dq_oe), .read_data_strobe_o(rds),
        .read_data_strobe_oe_o(rds_oe), .active_config_reg_i(8'h00),
        .active_is_volatile_i(act_vol), .volatile_config_reg_i(vcfg),
        .nv_load_i(nv_load), .nv_load_value_i(nv_val),
        .nonvolatile_config_reg_o(nonvolatile_config_reg), .hybrid_en_i(hyb),
        .wrap_len_i(wlen), .mem_addr_o(maddr), .mem_rd_o(mem_rd),
        .mem_data_i(mdata), .busy_o(busy));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic rd(input logic rw, input logic lin, input logic [24:0] a0,
                      input int lat, input int nw, input logic tm);
        logic [24:0] m;
        logic [24:0] a;
        int wt;
        int idx;
        m = (wlen == 2'h0) ? 25'h0000007 :
            (wlen == 2'h1) ? 25'h000000F : 25'h000001F;
        wt = lat - (16 - a0[3:0]);
        dfrb_host_model_inst.run({rw, 1'h0, lin, 7'h00, a0[24:3], 13'h0000,
                                  a0[2:0]}, 2 * (lat + nw + 18));
        if (rw !== 1'h1) begin
            cmp(dfrb_host_model_inst.got.size(), 0);
            return;
        end
        for (int w = 0; w < nw; w++) begin
            if (lin) a = a0 + 25'(w);
            else if (hyb && w > m) a = (a0 | m) + 25'(w) - m;
            else a = (a0 & ~m) | ((a0 + 25'(w)) & m);
            idx = 2 * lat - 1 + 2 * w;
            if (lin && w >= 16 - a0[3:0] && wt > 0) idx += 2 * wt;
            cmp(dfrb_host_model_inst.got[2*w], a[7:0] ^ 8'hFF);
            cmp(dfrb_host_model_inst.got[2*w+1], a[7:0]);
            if (tm) cmp(dfrb_host_model_inst.at[2*w], idx);
        end
    endtask : rd
    task automatic t_codes;
        for (int c = 0; c < 13; c++) begin
            @(negedge clk_i);
            vcfg = (c == 12) ? 8'hF0 : 8'(c << 4); // Last is reserved
            rd(1'h1, 1'h1, 25'h0000000, (c == 12) ? 16 : c + 5, 4, 1'h1);
        end
    endtask : t_codes
    task automatic t_linear;
        vcfg = 8'hB0;
        rd(1'h1, 1'h1, 25'h0000003, 16, 18, 1'h1);
        vcfg = 8'h00;
        rd(1'h1, 1'h1, 25'h0000009, 5, 10, 1'h1);
        rd(1'h1, 1'h1, 25'h1FFFFFE, 5, 6, 1'h1);
    endtask : t_linear
    task automatic t_wrap;
        wlen = 2'h0;
        rd(1'h1, 1'h0, 25'h0000005, 5, 12, 1'h1);
        wlen = 2'h1;
        rd(1'h1, 1'h0, 25'h000001B, 5, 20, 1'h1);
        wlen = 2'h2; // Crossing wait is optional here, so bytes only
        rd(1'h1, 1'h0, 25'h0000023, 5, 40, 1'h0);
        wlen = 2'h0;
        hyb = 1'h1;
        rd(1'h1, 1'h0, 25'h0000006, 5, 14, 1'h1);
        hyb = 1'h0;
    endtask : t_wrap
    task automatic t_nv;
        nv_load = 1'h1;
        @(negedge clk_i);
        nv_load = 1'h0;
        cmp(nonvolatile_config_reg, 8'h00);
        act_vol = 1'h0;
        vcfg = 8'hB0;
        rd(1'h1, 1'h1, 25'h0000000, 5, 4, 1'h1);
        act_vol = 1'h1;
    endtask : t_nv
    task automatic t_abort;
        vcfg = 8'h00;
        dfrb_host_model_inst.run(48'hA00000000000, 16);
        cmp(dq_oe, 1'h0);
        cmp(rds_oe, 1'h0);
        rd(1'h0, 1'h1, 25'h0000010, 5, 0, 1'h0);
    endtask : t_abort
    task automatic give_verdict;
        $display("n_fail=%0d compares=%0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (10) @(negedge clk_i);
        rst_b_i = 1'h1;
        repeat (4) @(negedge clk_i);
        cmp(nonvolatile_config_reg, 8'hB0);
        t_codes();
        t_linear();
        t_wrap();
        t_nv();
        t_abort();
        give_verdict();
    end
endmodule : tb_top
